/* File: inc/spcf_map.vh */
// Purpose: Register map, field positions, reset values and counts of the SPI format and select block.
// Assumes: APB with 32-bit data; each register sits at byte address four times its index.
// Notes: Definitions only.
`ifndef SPCF_MAP_VH
`define SPCF_MAP_VH

// Register indices; byte address is index times four.
`define SPCF_IDX_CTRL 10'h0F3
`define SPCF_IDX_STAT 10'h0F4
`define SPCF_IDX_DATA 10'h0F5
`define SPCF_IDX_IMSK 10'h0F6
`define SPCF_IDX_ISTS 10'h0F7

// Control register fields.
`define SPCF_C_SELECT_OUTPUT_ENABLE 7
`define SPCF_C_EN 6
`define SPCF_C_LSBF 5
`define SPCF_C_MASTER_SELECT 4
`define SPCF_C_CLOCK_IDLE_LEVEL 3
`define SPCF_C_SAMPLE_EDGE_SELECT 2
`define SPCF_CTRL_RST 8'h00

// Status register fields.
`define SPCF_S_DONE 7
`define SPCF_S_WRITE_COLLISION_FLAG 6
`define SPCF_S_OVF 5
`define SPCF_S_MASTER_FAULT_FLAG 4
`define SPCF_S_DISF 3
`define SPCF_STAT_RST 8'h00

// Interrupt status and mask bits.
`define SPCF_I_DONE 3
`define SPCF_I_WRITE_COLLISION_FLAG 2
`define SPCF_I_OVF 1
`define SPCF_I_MASTER_FAULT_FLAG 0
`define SPCF_IMSK_RST 4'h0

// Half periods of the shift clock per rate code, as terminal counts one below the number of system clocks.
`define SPCF_HALF_DIV16 6'h07
`define SPCF_HALF_DIV32 6'h0F
`define SPCF_HALF_DIV64 6'h1F
`define SPCF_HALF_DIV128 6'h3F

// Shift clock edges per byte.
`define SPCF_EDGES 5'h10
`endif

/* File: rtl/spcf_rate_div.v */
// Purpose: Shift clock divider giving one enable pulse per half period of the master shift clock.
// Assumes: Single system clock; run low holds the counter cleared.
// Notes: The pulse is registered so the first edge lands a full half period after start.
`timescale 1ns/1ps
`default_nettype none
`include "spcf_map.vh"

module spcf_rate_div (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [1:0] rate,
    output reg tick_q
);
    reg [5:0] cnt_q;
    reg [5:0] top;

    // Terminal count per divider code: 16, 32, 64 or 128 system clocks per bit.
    always @* begin
        case (rate)
            2'b00: top = `SPCF_HALF_DIV16;
            2'b01: top = `SPCF_HALF_DIV32;
            2'b10: top = `SPCF_HALF_DIV64;
            default: top = `SPCF_HALF_DIV128;
        endcase
    end

    // Free count while running; a stopped divider restarts from zero so bit timing is exact.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 6'h00;
            tick_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= 6'h00;
            tick_q <= 1'b0;
        end else if (cnt_q == top) begin
            cnt_q <= 6'h00;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 6'h01;
            tick_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/spcf_core.v */
// Purpose: SPI unit with clock format, rate divider, select pin handling and status flags.
// Assumes: All pin inputs are synchronous to pclk; APB slave with zero wait states.
// Notes: Each two-way pin is split into input, output and active-low output enable.
// Summary of operation
// - Idle serial clock level follows the clock idle level bit.
// - Phase bit 0 samples on first clock edge, 1 on second.
// - Rate code 00/01/10/11 divides system clock by 16/32/64/128.
// - Master with fault detect enabled watches select pin for mode fault.
// - Slave uses select pin as active-low select held low whole access.
// - Master with fault detect off: select output enable drives select low per byte.
// - Transfer done flag set by hardware when a byte transfer finishes.
// - While done flag set, data writes are ignored and no transfer starts.
// - Status register resets to all zeros.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spcf_map.vh"

module spcf_core (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_q,
    output reg pready_q,
    output reg pslverr_q,
    output reg irq_q,
    input wire sclk_in,
    output reg sclk_out_q,
    output reg sclk_oe_n_q,
    input wire mosi_in,
    output reg mosi_out_q,
    output reg mosi_oe_n_q,
    input wire miso_in,
    output reg miso_out_q,
    output reg miso_oe_n_q,
    input wire ss_n_in,
    output reg ss_n_out_q,
    output reg ss_oe_n_q
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_FIN = 3'b100;

    // Shift one bit in at the end that leaves last, in the chosen bit order.
    function [7:0] spcf_shift;
        input [7:0] v;
        input lsb_first;
        input b;
        begin
            if (lsb_first) begin
                spcf_shift = {b, v[7:1]};
            end else begin
                spcf_shift = {v[6:0], b};
            end
        end
    endfunction

    reg [7:0] ctrl_q;
    reg done_q, write_collision_flag_q, ovf_q, master_fault_flag_q, disf_q;
    reg [3:0] imsk_q, ists_q;
    reg [2:0] st_q, st_d;
    reg [7:0] tx_q, tx_d, rx_q, rx_d, rbuf_q;
    reg [4:0] ecnt_q, ecnt_d;
    reg msclk_q;
    reg sclk_prev_q;
    reg [3:0] rd_clr_q;
    wire tick;

    wire en = ctrl_q[`SPCF_C_EN];
    wire master_select = ctrl_q[`SPCF_C_MASTER_SELECT];
    wire clock_idle_level = ctrl_q[`SPCF_C_CLOCK_IDLE_LEVEL];
    wire sample_edge_select = ctrl_q[`SPCF_C_SAMPLE_EDGE_SELECT];
    wire lsbf = ctrl_q[`SPCF_C_LSBF];
    wire [9:0] idx = paddr[11:2];
    wire acc = psel & penable & pready_q;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire wr_ctrl = wr & (idx == `SPCF_IDX_CTRL);
    wire wr_stat = wr & (idx == `SPCF_IDX_STAT);
    wire wr_data = wr & (idx == `SPCF_IDX_DATA);
    wire wr_imsk = wr & (idx == `SPCF_IDX_IMSK);
    wire rd_ists = rd & (idx == `SPCF_IDX_ISTS);
    wire mapped = (idx == `SPCF_IDX_CTRL) | (idx == `SPCF_IDX_STAT) | (idx == `SPCF_IDX_DATA) |
                  (idx == `SPCF_IDX_IMSK) | (idx == `SPCF_IDX_ISTS);

    // Fault when another master pulls select low while we are master with detection on.
    wire fault = en & master_select & ~disf_q & ~ss_n_in;
    // Slave is addressed only while the external master holds select low.
    wire slv_sel = en & ~master_select & ~ss_n_in;
    wire running = st_q[1];

    // Master edges come from the divider; slave edges from the pin, divider unused.
    wire m_edge = running & master_select & tick;
    wire s_edge = running & ~master_select & slv_sel & (sclk_in != sclk_prev_q);
    wire edge_ev = m_edge | s_edge;
    // Leading edge moves the clock away from its idle level.
    wire lead = master_select ? (msclk_q == clock_idle_level) : (sclk_in != clock_idle_level);
    // Phase 0 samples leading edges, phase 1 trailing edges.
    wire smp_ev = edge_ev & (lead ^ sample_edge_select);
    // With phase 1 the first leading edge only presents the first bit.
    wire shf_ev = edge_ev & ~(lead ^ sample_edge_select) & ~(sample_edge_select & (ecnt_q == 5'h00));
    wire in_bit = master_select ? miso_in : mosi_in;
    wire last_edge = edge_ev & (ecnt_q == `SPCF_EDGES - 5'h01);

    // Writes are dropped while done is set; collision when writing into a live transfer.
    wire start_m = wr_data & ~done_q & en & master_select & st_q[0] & ~fault;
    wire ev_write_collision_flag = wr_data & ~done_q & ~st_q[0];
    wire ev_fin = st_q[2];
    wire ev_ovf = ev_fin & done_q;

    spcf_rate_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(running & master_select),
        .rate(ctrl_q[1:0]),
        .tick_q(tick)
    );

    // Transfer sequencing, shift data and edge count.
    always @* begin
        st_d = st_q;
        tx_d = tx_q;
        rx_d = rx_q;
        ecnt_d = ecnt_q;
        case (st_q)
            ST_IDLE: begin
                ecnt_d = 5'h00;
                if (wr_data & ~done_q) begin
                    tx_d = pwdata[7:0];
                end
                if (start_m) begin
                    st_d = ST_RUN;
                end else if (slv_sel & ~done_q) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (smp_ev) begin
                    rx_d = spcf_shift(rx_q, lsbf, in_bit);
                end
                if (shf_ev) begin
                    tx_d = spcf_shift(tx_q, lsbf, 1'b0);
                end
                if (edge_ev) begin
                    ecnt_d = ecnt_q + 5'h01;
                end
                if (fault | ~en | (~master_select & ~slv_sel)) begin
                    st_d = ST_IDLE;
                end else if (last_edge) begin
                    st_d = ST_FIN;
                end
            end
            ST_FIN: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers and the slave clock history used for edge detection.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            ecnt_q <= 5'h00;
            sclk_prev_q <= 1'b0;
            rbuf_q <= 8'h00;
        end else begin
            st_q <= st_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            ecnt_q <= ecnt_d;
            sclk_prev_q <= sclk_in;
            // Receive buffer keeps the older byte if software has not taken it yet.
            if (ev_fin & ~done_q) begin
                rbuf_q <= rx_q;
            end
        end
    end

    // Master clock toggles on every divider pulse except in a mode fault cycle, and rests at the idle level.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msclk_q <= 1'b0;
        end else if (m_edge & ~fault) begin
            msclk_q <= ~msclk_q;
        end else if (~running) begin
            msclk_q <= clock_idle_level;
        end
    end

    // Control register; mode fault drops master mode and wins over a same-cycle write.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `SPCF_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[7:0];
            end
            if (fault) begin
                ctrl_q[`SPCF_C_MASTER_SELECT] <= 1'b0;
            end
        end
    end

    // Status flags: hardware set wins over a software write of zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            ovf_q <= 1'b0;
            master_fault_flag_q <= 1'b0;
            disf_q <= 1'b0;
        end else begin
            if (wr_stat) begin
                done_q <= done_q & pwdata[`SPCF_S_DONE];
                write_collision_flag_q <= write_collision_flag_q & pwdata[`SPCF_S_WRITE_COLLISION_FLAG];
                ovf_q <= ovf_q & pwdata[`SPCF_S_OVF];
                master_fault_flag_q <= master_fault_flag_q & pwdata[`SPCF_S_MASTER_FAULT_FLAG];
                disf_q <= pwdata[`SPCF_S_DISF];
            end
            if (ev_fin) begin
                done_q <= 1'b1;
            end
            if (ev_write_collision_flag) begin
                write_collision_flag_q <= 1'b1;
            end
            if (ev_ovf) begin
                ovf_q <= 1'b1;
            end
            if (fault) begin
                master_fault_flag_q <= 1'b1;
            end
        end
    end

    // Sticky interrupt status; a read clears only the bits it returned, so new events survive.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_q <= 4'h0;
            imsk_q <= `SPCF_IMSK_RST;
            irq_q <= 1'b0;
        end else begin
            if (wr_imsk) begin
                imsk_q <= pwdata[3:0];
            end
            ists_q <= (ists_q & ~(rd_ists ? rd_clr_q : 4'h0)) |
                      {ev_fin, ev_write_collision_flag, ev_ovf, fault};
            irq_q <= |(ists_q & imsk_q);
        end
    end

    // APB slave: read data captured in setup, answer in the first access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            rd_clr_q <= 4'h0;
        end else begin
            pready_q <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~mapped;
            if (psel & ~penable) begin
                rd_clr_q <= ists_q;
                case (idx)
                    `SPCF_IDX_CTRL: prdata_q <= {24'h000000, ctrl_q};
                    `SPCF_IDX_STAT: prdata_q <= {24'h000000, done_q, write_collision_flag_q, ovf_q, master_fault_flag_q, disf_q, 3'b000};
                    `SPCF_IDX_DATA: prdata_q <= {24'h000000, rbuf_q};
                    `SPCF_IDX_IMSK: prdata_q <= {28'h0000000, imsk_q};
                    `SPCF_IDX_ISTS: prdata_q <= {28'h0000000, ists_q};
                    default: prdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Pin drivers; enables are active low and released whenever the unit is off.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_out_q <= 1'b0;
            sclk_oe_n_q <= 1'b1;
            mosi_out_q <= 1'b0;
            mosi_oe_n_q <= 1'b1;
            miso_out_q <= 1'b0;
            miso_oe_n_q <= 1'b1;
            ss_n_out_q <= 1'b1;
            ss_oe_n_q <= 1'b1;
        end else begin
            sclk_out_q <= (running & master_select) ? msclk_q : clock_idle_level;
            sclk_oe_n_q <= ~(en & master_select);
            mosi_out_q <= lsbf ? tx_d[0] : tx_d[7];
            mosi_oe_n_q <= ~(en & master_select);
            miso_out_q <= lsbf ? tx_d[0] : tx_d[7];
            miso_oe_n_q <= ~slv_sel;
            // Automatic select: low for each byte, high while idle.
            // Held low through the finish cycle so select never moves with the last clock edge.
            ss_n_out_q <= ~((running | st_q[2]) & master_select);
            ss_oe_n_q <= ~(en & master_select & disf_q & ctrl_q[`SPCF_C_SELECT_OUTPUT_ENABLE]);
        end
    end
endmodule
`default_nettype wire

/* File: verification/spcf_spi_peer.sv */
// Purpose: Behavioural far-side SPI peer that exchanges one byte with a master.
// Assumes: Mode bits are set by the bench to match the master before a byte.
// Notes: A released output shows the inverse of its last bit, never a held value.
`timescale 1ns/1ps
`default_nettype none
module spcf_spi_peer (
    input wire sclk,
    input wire ss_n,
    input wire mosi,
    input wire clock_idle_level,
    input wire sample_edge_select,
    input wire [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic [8:0] sh = 9'h000;
    logic last = 1'b0;
    // Phase 1 parks a dummy bit so the first leading edge presents the top bit.
    always @(negedge ss_n) sh = sample_edge_select ? {~tx[7], tx} : {tx, 1'b0};
    // Remember the last bit so the released line can show its inverse.
    always @(posedge ss_n) last = sh[8];
    // A leading edge leaves the idle level; the phase picks sampling or shifting.
    always @(sclk) begin
        if (!ss_n) begin
            if ((sclk != clock_idle_level) != sample_edge_select) rx = {rx[6:0], mosi};
            else sh = {sh[7:0], 1'b0};
        end
    end
    assign miso = ss_n ? ~last : sh[8];
endmodule
`default_nettype wire

/* File: verification/spcf_core_assertions.sv */
// Purpose: Port-level checks of the SPI format and select block.
// Assumes: Control and status bits are shadowed from APB writes.
// Notes: Shadows miss hardware changes such as a mode fault clearing the master bit; checks use that bit only as a past condition a stale value cannot break.
`timescale 1ns/1ps
`default_nettype none
`include "spcf_map.vh"
module spcf_core_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready_q,
    input wire pslverr_q,
    input wire sclk_out_q,
    input wire sclk_oe_n_q,
    input wire ss_n_in,
    input wire ss_n_out_q,
    input wire ss_oe_n_q,
    input wire miso_oe_n_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [7:0] ctl_q;
    reg dis_q;
    reg prev_q;
    reg [4:0] ecnt_q;
    reg [10:0] cnt_q;
    reg [10:0] lowc_q;
    wire [9:0] idx = paddr[11:2];
    wire wr = psel && penable && pready_q && pwrite;
    wire tog = sclk_out_q != prev_q;
    // Shadow the software bits; count cycles between clock toggles and while selected.
    always @(posedge pclk) begin
        if (!presetn) begin
            ctl_q <= 8'h00;
            dis_q <= 1'b0;
        end else if (wr && idx == `SPCF_IDX_CTRL) begin
            ctl_q <= pwdata[7:0];
        end else if (wr && idx == `SPCF_IDX_STAT) begin
            dis_q <= pwdata[3];
        end
        prev_q <= presetn ? sclk_out_q : 1'b0;
        cnt_q <= (!presetn || tog) ? 11'h001 : cnt_q + 11'h001;
        ecnt_q <= (!presetn || ss_n_out_q) ? 5'h00 : ecnt_q + {4'h0, tog};
        lowc_q <= (!presetn || ss_n_out_q) ? 11'h000 : lowc_q + 11'h001;
    end
    a_pready_pulse: assert property ((psel && !penable) |=> pready_q ##1 !pready_q)
        else $error("pready is not a one-cycle answer");
    a_unmapped_err: assert property ((psel && !penable) |=>
        pslverr_q == (idx < `SPCF_IDX_CTRL || idx > `SPCF_IDX_ISTS)) else $error("slave error wrong");
    a_idle_level: assert property ((!sclk_oe_n_q && ss_n_out_q && $past(ss_n_out_q) && $stable(ctl_q[3]))
        |-> sclk_out_q == ctl_q[3]) else $error("idle clock level wrong");
    a_half_period: assert property ((tog && !ss_n_out_q && ecnt_q != 5'h00) |->
        cnt_q == (11'h008 << ctl_q[1:0])) else $error("half period wrong");
    a_byte_bounded: assert property (lowc_q <= 11'h44C) else $error("select held too long");
    a_select_drive: assert property (!ss_oe_n_q |-> $past(ctl_q[7] && ctl_q[6] && ctl_q[4] && dis_q))
        else $error("select driven wrongly");
    a_slave_no_clk: assert property (!sclk_oe_n_q |-> $past(ctl_q[4])) else $error("slave drives clock");
    a_miso_drive: assert property (!miso_oe_n_q |-> !$past(ss_n_in)) else $error("unselected output");
    cover property ($fell(ss_n_out_q));
    cover property (pslverr_q);
    cover property (!miso_oe_n_q);
endmodule
bind spcf_core spcf_core_chk spcf_core_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .sclk_out_q(sclk_out_q), .sclk_oe_n_q(sclk_oe_n_q), .ss_n_in(ss_n_in), .ss_n_out_q(ss_n_out_q),
    .ss_oe_n_q(ss_oe_n_q), .miso_oe_n_q(miso_oe_n_q));
`default_nettype wire

/* File: verification/spcf_core_bench.sv */
// Purpose: Self-checking bench for the SPI format and select block.
// Assumes: Pins are resolved here from each party's enables.
// Notes: Read expectations queue up and a monitor compares them as answers arrive.
`timescale 1ns/1ps
`default_nettype none
`include "spcf_map.vh"
module spcf_core_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ss_drv = 1'b1, sck_drv = 1'b0, mo_drv = 1'b0;
    logic clock_idle_level = 1'b0, sample_edge_select = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, rs = 32'h00010DCA;
    logic [7:0] ptx = 8'h00, srx = 8'h00;
    logic [2:0] i;
    logic [31:0] expq[$];
    integer n_errors = 0, compares = 0, nfall = 0, k;
    wire [31:0] prdata_q;
    wire [7:0] prx;
    wire pready_q, pslverr_q, irq_q, sclk_out_q, sclk_oe_n_q, mosi_out_q, mosi_oe_n_q, peer_miso;
    wire miso_out_q, miso_oe_n_q, ss_n_out_q, ss_oe_n_q;
    wire sck = sclk_oe_n_q ? sck_drv : sclk_out_q;
    wire mosi = mosi_oe_n_q ? mo_drv : mosi_out_q;
    wire miso = miso_oe_n_q ? peer_miso : miso_out_q;
    wire ss_n = ss_oe_n_q ? ss_drv : ss_n_out_q;
    spcf_core spcf_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .irq_q(irq_q), .sclk_in(sck), .sclk_out_q(sclk_out_q), .sclk_oe_n_q(sclk_oe_n_q), .mosi_in(mosi),
        .mosi_out_q(mosi_out_q), .mosi_oe_n_q(mosi_oe_n_q), .miso_in(miso), .miso_out_q(miso_out_q),
        .miso_oe_n_q(miso_oe_n_q), .ss_n_in(ss_n), .ss_n_out_q(ss_n_out_q), .ss_oe_n_q(ss_oe_n_q));
    spcf_spi_peer spcf_spi_peer_i (.sclk(sck), .ss_n(ss_n), .mosi(mosi), .clock_idle_level(clock_idle_level), .sample_edge_select(sample_edge_select),
        .tx(ptx), .miso(peer_miso), .rx(prx));
    always #10 pclk = ~pclk;
    // Count master byte starts so a refused start shows up.
    always @(negedge ss_n_out_q) nfall = nfall + 1;
    function logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        begin
            compares = compares + 1;
            if (s !== e) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t seen %h expected %h", $time, s, e);
            end
        end
    endtask
    task end_of_test;
        begin
            if (n_errors == 0 && compares > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // One APB transfer; the request holds until pready is seen at an edge.
    task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= {idx, 2'b00};
            pwdata <= {24'h000000, d};
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready_q !== 1'b1 && n < 20);
            psel <= 1'b0;
            penable <= 1'b0;
            if (n == 20) begin
                n_errors = n_errors + 1;
                end_of_test;
            end
        end
    endtask
    task rd(input logic [9:0] idx, input logic [31:0] e);
        begin
            expq.push_back(e);
            apb(1'b0, idx, 8'h00);
        end
    endtask
    task wait_irq;
        integer n;
        begin
            n = 0;
            while (irq_q !== 1'b1 && n < 3000) begin
                @(posedge pclk);
                n = n + 1;
            end
            if (n == 3000) begin
                n_errors = n_errors + 1;
                end_of_test;
            end
        end
    endtask
    // Compare each read answer with the oldest queued expectation.
    always @(posedge pclk) begin
        if (psel && penable && pready_q === 1'b1 && !pwrite && expq.size() > 0) begin
            chk(prdata_q, expq.pop_front());
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SPCF_IDX_CTRL, 32'h0);
        rd(`SPCF_IDX_STAT, 32'h0);
        rd(10'h001, 32'h0);
        apb(1'b1, `SPCF_IDX_IMSK, 8'h09);
        apb(1'b1, `SPCF_IDX_STAT, 8'h08);
        // Every clock mode, each with a different rate code, exchanges a random byte.
        for (i = 3'h0; i < 3'h4; i = i + 3'h1) begin
            rs = lfsr(rs);
            clock_idle_level <= i[1];
            sample_edge_select <= i[0];
            ptx <= rs[15:8];
            apb(1'b1, `SPCF_IDX_CTRL, {4'hD, i[1], i[0], i[1:0]});
            apb(1'b1, `SPCF_IDX_DATA, rs[7:0]);
            wait_irq;
            chk(prx, rs[7:0]);
            chk(sclk_out_q, i[1]);
            rd(`SPCF_IDX_DATA, ptx);
            rd(`SPCF_IDX_STAT, 32'h88);
            apb(1'b1, `SPCF_IDX_DATA, 8'h5A);
            rd(`SPCF_IDX_ISTS, 32'h8);
            chk(nfall, i + 3'h1);
            apb(1'b1, `SPCF_IDX_STAT, 8'h08);
            chk(irq_q, 1'b0);
        end
        // A master with fault detection sees its select pulled low.
        apb(1'b1, `SPCF_IDX_STAT, 8'h00);
        apb(1'b1, `SPCF_IDX_CTRL, 8'h50);
        ss_drv <= 1'b0;
        wait_irq;
        rd(`SPCF_IDX_STAT, 32'h10);
        rd(`SPCF_IDX_CTRL, 32'h40);
        rd(`SPCF_IDX_ISTS, 32'h1);
        ss_drv <= 1'b1;
        apb(1'b1, `SPCF_IDX_STAT, 8'h00);
        // Slave byte on an external clock far faster than the divider setting.
        apb(1'b1, `SPCF_IDX_CTRL, 8'h43);
        rs = lfsr(rs);
        apb(1'b1, `SPCF_IDX_DATA, rs[15:8]);
        ss_drv <= 1'b0;
        for (k = 0; k < 8; k = k + 1) begin
            mo_drv <= rs[7 - k];
            repeat (4) @(posedge pclk);
            srx = {srx[6:0], miso_out_q};
            sck_drv <= 1'b1;
            repeat (4) @(posedge pclk);
            sck_drv <= 1'b0;
        end
        chk(miso_oe_n_q, 1'b0);
        chk(srx, rs[15:8]);
        chk(sclk_oe_n_q, 1'b1);
        wait_irq;
        ss_drv <= 1'b1;
        mo_drv <= ~rs[0];
        rd(`SPCF_IDX_DATA, {24'h000000, rs[7:0]});
        rd(`SPCF_IDX_STAT, 32'h80);
        end_of_test;
    end
endmodule
`default_nettype wire
